// ### rtl/cnmt_slave.sv
// CANopen slave network management: guarding, NMT commands, boot-up, emergency.
// Assumes a frame-level CAN controller on the same clock; station_in is a switch.
// Behaviour
// - Guard remote frame on 0x700+node gets a one-byte state reply, same id.
// - Reply byte: toggle in bit 7, state code below; toggle flips per reply.
// - First guard reply after guarding starts carries toggle zero.
// - State codes: 0 init, 4 stopped, 5 operational, 127 pre-operational.
// - Supervision starts at first guard frame; missing frame in window flags error.
// - Communication mode 1 turns that error into alarm and stop; 0 ignores it.
// - Guarding and heartbeat never run together.
// - Heartbeat and supervision settings come from the master, not kept.
// - After initialization enter pre-operational and send boot-up.
// - Commands on id 0x000: command byte, then node; node 0 means all.
// - 0x01 start, 0x02 stop, 0x80/0x81 pre-operational, 0x82 reset comms.
// - Only the master commands; the slave never replies to commands.
// - A fatal fault sends an eight-byte emergency frame at top priority.
// - Emergency: code bytes 0-1, class byte 2, state words bytes 4-7.
// - Codes 0x3210 overvoltage, 0x3220 undervoltage, 0x4210 overtemperature.
// - Codes 0x7331 encoder absent, 0x8100 bus error, 0x81FF bus timeout.
// - Class bits: general, current, voltage, temperature, comms, profile, encoder.
// - Emergency identifier is 0x80 plus station number.
// - Guard time defaults to 1000 ms and guard factor to 3.
module cnmt_slave #(
   parameter int unsigned MS_CYCLES = cnmt_pkg::MS_CYC
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   // Station switch
   input  wire logic [6:0]  station_in,
   // Settings written by the master
   input  wire logic        cfg_wr_in,
   input  wire logic [1:0]  cfg_sel_in,
   input  wire logic [15:0] cfg_data_in,
   // Received frames
   input  wire logic        rx_valid_in,
   input  wire logic [10:0] rx_id_in,
   input  wire logic        rx_rtr_in,
   input  wire logic [3:0]  rx_dlc_in,
   input  wire logic [63:0] rx_data_in,
   // Frames to send
   output logic             tx_valid_out,
   input  wire logic        tx_ready_in,
   output logic [10:0]      tx_id_out,
   output logic [3:0]       tx_dlc_out,
   output logic [63:0]      tx_data_out,
   // Drive faults
   input  wire logic        flt_ovv_in,
   input  wire logic        flt_uv_in,
   input  wire logic        flt_ot_in,
   input  wire logic        flt_enc_in,
   input  wire logic        flt_bus_in,
   input  wire logic [15:0] err_state1_in,
   input  wire logic [15:0] err_state2_in,
   // Status
   output logic [6:0]       node_state_out,
   output logic             guard_active_out,
   output logic             comm_err_out,
   output logic             alarm_out,
   output logic [7:0]       fault_class_out
);
   cnmt_tmr_if tif ();

   cnmt_guard_tmr #(.MS_CYCLES(MS_CYCLES)) u_tmr (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .tif       (tif)
   );

   // Switch synchroniser
   logic [6:0] st1_q, st2_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st1_q <= '0;
         st2_q <= '0;
      end else begin
         st1_q <= station_in;
         st2_q <= st1_q;
      end
   end

   // Settings, loaded with the package defaults at power-up rather than kept
   logic [15:0] gtime_q, gtime_d, hb_q, hb_d;
   logic [7:0]  gfact_q, gfact_d;
   logic        cmode_q, cmode_d;
   always_comb begin
      gtime_d = gtime_q;
      gfact_d = gfact_q;
      hb_d    = hb_q;
      cmode_d = cmode_q;
      if (cfg_wr_in) begin
         case (cfg_sel_in)
            cnmt_pkg::CFG_GTIME:  gtime_d = cfg_data_in;
            cnmt_pkg::CFG_GFACT:  gfact_d = cfg_data_in[7:0];
            cnmt_pkg::CFG_HBTIME: hb_d    = cfg_data_in;
            cnmt_pkg::CFG_CMODE:  cmode_d = cfg_data_in[0];
            default:              gtime_d = gtime_q;
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gtime_q <= cnmt_pkg::GTIME_DEF;
         gfact_q <= cnmt_pkg::GFACT_DEF;
         hb_q    <= cnmt_pkg::HBTIME_DEF;
         cmode_q <= cnmt_pkg::CMODE_DEF;
      end else begin
         gtime_q <= gtime_d;
         gfact_q <= gfact_d;
         hb_q    <= hb_d;
         cmode_q <= cmode_d;
      end
   end

   function automatic logic [15:0] ecode(input logic [2:0] i);
      case (i)
         3'h0:    ecode = cnmt_pkg::EC_OVV;
         3'h1:    ecode = cnmt_pkg::EC_UV;
         3'h2:    ecode = cnmt_pkg::EC_OT;
         3'h3:    ecode = cnmt_pkg::EC_ENC;
         3'h4:    ecode = cnmt_pkg::EC_BUS;
         default: ecode = cnmt_pkg::EC_TMO;
      endcase
   endfunction

   cnmt_pkg::cnmt_state_t st_q, st_d;
   logic [6:0]  node_q, node_d;
   logic [1:0]  icnt_q, icnt_d;
   logic        tog_q, tog_d, gact_q, gact_d, gpend_q, gpend_d;
   logic        tmo_q, tmo_d, alarm_q, alarm_d;
   logic [4:0]  fprev_q;
   logic [5:0]  epend_q, epend_d;
   logic [7:0]  fcls_q, fcls_d;
   logic        txv_q, txv_d;
   logic [10:0] txid_q, txid_d;
   logic [3:0]  txdlc_q, txdlc_d;
   logic [63:0] txdat_q, txdat_d;
   logic [4:0]  flt;
   logic [5:0]  fevt;
   logic        run, nmt_hit, grd_hit, tmo_evt, ld_boot, ld_emcy, ld_guard;
   logic [2:0]  eidx;
   logic [7:0]  cs;

   assign flt = {flt_bus_in, flt_enc_in, flt_ot_in, flt_uv_in, flt_ovv_in};
   assign run = (st_q != cnmt_pkg::CNMT_INIT);
   assign cs  = rx_data_in[7:0];
   assign nmt_hit = run && rx_valid_in && !rx_rtr_in && rx_id_in == cnmt_pkg::ID_NMT
                    && rx_dlc_in >= cnmt_pkg::DLC_NMT
                    && (rx_data_in[15:8] == 8'h00 || rx_data_in[14:8] == node_q
                        && !rx_data_in[15]);
   // Guarding only while no heartbeat time is set
   assign grd_hit = run && rx_valid_in && rx_rtr_in && hb_q == 16'h0000
                    && rx_id_in == cnmt_pkg::ID_GUARD + 11'(node_q);
   assign tmo_evt = tif.expire && gact_q && hb_q == 16'h0000;
   assign fevt = {tmo_evt && cmode_q == cnmt_pkg::CMODE_STOP, flt & ~fprev_q};

   always_comb begin
      eidx = 3'h5;
      for (int i = cnmt_pkg::FS_N - 1; i >= 0; i--) begin
         if (epend_q[i]) begin
            eidx = 3'(i);
         end
      end
   end

   // Emergency first, then guard replies; boot-up only leaves the init state
   assign ld_boot  = !run && icnt_q == cnmt_pkg::INIT_WAIT && !txv_q;
   assign ld_emcy  = run && !txv_q && epend_q != '0;
   assign ld_guard = run && !txv_q && epend_q == '0 && gpend_q;

   assign tif.restart = grd_hit;
   assign tif.halt    = hb_q != 16'h0000 || (nmt_hit && cs == cnmt_pkg::CS_RSTCOM);
   assign tif.time_ms = gtime_q;
   assign tif.factor  = gfact_q;

   always_comb begin
      st_d    = st_q;
      node_d  = node_q;
      icnt_d  = icnt_q;
      tog_d   = tog_q && !(grd_hit && !gact_q);
      gact_d  = (gact_q || grd_hit) && hb_q == 16'h0000;
      gpend_d = (gpend_q || grd_hit) && hb_q == 16'h0000;
      tmo_d   = tmo_q || tmo_evt;
      alarm_d = alarm_q;
      epend_d = epend_q | fevt;
      txv_d   = txv_q && !tx_ready_in;
      txid_d  = txid_q;
      txdlc_d = txdlc_q;
      txdat_d = txdat_q;
      fcls_d  = 8'h00;
      fcls_d[cnmt_pkg::FC_VOLT] = flt[cnmt_pkg::FS_OVV] | flt[cnmt_pkg::FS_UV];
      fcls_d[cnmt_pkg::FC_TEMP] = flt[cnmt_pkg::FS_OT];
      fcls_d[cnmt_pkg::FC_ENC]  = flt[cnmt_pkg::FS_ENC];
      fcls_d[cnmt_pkg::FC_COMM] = flt[cnmt_pkg::FS_BUS] | tmo_q;
      fcls_d[cnmt_pkg::FC_GEN]  = |fcls_d;
      if (!run) begin
         // Switch read only while initializing, after the synchroniser settles
         node_d = st2_q;
         if (icnt_q != cnmt_pkg::INIT_WAIT) begin
            icnt_d = icnt_q + 2'h1;
         end
         epend_d = '0;
      end
      if (ld_boot) begin
         txv_d   = 1'b1;
         txid_d  = cnmt_pkg::ID_GUARD + 11'(node_q);
         txdlc_d = cnmt_pkg::DLC_GUARD;
         txdat_d = '0;
         st_d    = cnmt_pkg::CNMT_PREOP;
      end else if (ld_emcy) begin
         txv_d   = 1'b1;
         txid_d  = cnmt_pkg::ID_EMCY + 11'(node_q);
         txdlc_d = cnmt_pkg::DLC_EMCY;
         txdat_d = {err_state2_in, err_state1_in, 8'h00, fcls_q, ecode(eidx)};
         epend_d[eidx] = fevt[eidx];
      end else if (ld_guard) begin
         txv_d   = 1'b1;
         txid_d  = cnmt_pkg::ID_GUARD + 11'(node_q);
         txdlc_d = cnmt_pkg::DLC_GUARD;
         txdat_d = {56'h0, tog_q, 7'(st_q)};
         tog_d   = ~tog_q;
         gpend_d = grd_hit;
      end
      // Commands change state, reset comms also clears toggle, guarding, error and alarm; nothing is queued in reply
      if (nmt_hit) begin
         case (cs)
            cnmt_pkg::CS_START:  st_d = cnmt_pkg::CNMT_OPER;
            cnmt_pkg::CS_STOP:   st_d = cnmt_pkg::CNMT_STOPPED;
            cnmt_pkg::CS_PREOP,
            cnmt_pkg::CS_PREOP2: st_d = cnmt_pkg::CNMT_PREOP;
            cnmt_pkg::CS_RSTCOM: begin
               st_d    = cnmt_pkg::CNMT_INIT;
               icnt_d  = 2'h0;
               tog_d   = 1'b0;
               gact_d  = 1'b0;
               gpend_d = 1'b0;
               tmo_d   = tmo_evt;
               alarm_d = 1'b0;
            end
            default:             st_d = st_d;
         endcase
      end
      if (tmo_evt && cmode_q == cnmt_pkg::CMODE_STOP) begin
         alarm_d = 1'b1;
         st_d    = cnmt_pkg::CNMT_STOPPED;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q    <= cnmt_pkg::CNMT_INIT;
         node_q  <= '0;
         icnt_q  <= '0;
         tog_q   <= 1'b0;
         gact_q  <= 1'b0;
         gpend_q <= 1'b0;
         tmo_q   <= 1'b0;
         alarm_q <= 1'b0;
         fprev_q <= '0;
         epend_q <= '0;
         fcls_q  <= '0;
         txv_q   <= 1'b0;
         txid_q  <= '0;
         txdlc_q <= '0;
         txdat_q <= '0;
      end else begin
         st_q    <= st_d;
         node_q  <= node_d;
         icnt_q  <= icnt_d;
         tog_q   <= tog_d;
         gact_q  <= gact_d;
         gpend_q <= gpend_d;
         tmo_q   <= tmo_d;
         alarm_q <= alarm_d;
         fprev_q <= flt;
         epend_q <= epend_d;
         fcls_q  <= fcls_d;
         txv_q   <= txv_d;
         txid_q  <= txid_d;
         txdlc_q <= txdlc_d;
         txdat_q <= txdat_d;
      end
   end

   assign tx_valid_out     = txv_q;
   assign tx_id_out        = txid_q;
   assign tx_dlc_out       = txdlc_q;
   assign tx_data_out      = txdat_q;
   assign node_state_out   = st_q;
   assign guard_active_out = gact_q;
   assign comm_err_out     = tmo_q;
   assign alarm_out        = alarm_q;
   assign fault_class_out  = fcls_q;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence boot_leave;
      !run ##0 ld_boot;
   endsequence
   sequence rst_cmd;
      nmt_hit && cs == cnmt_pkg::CS_RSTCOM && !tmo_evt;
   endsequence

   guard_reply_fmt_a: assert property (ld_guard |=> txv_q
      && txdat_q[cnmt_pkg::TOG_BIT] == $past(tog_q) && txdat_q[6:0] == $past(st_q)
      && txdlc_q == cnmt_pkg::DLC_GUARD) else $error("guard reply malformed");
   toggle_flip_a: assert property (ld_guard && !nmt_hit |=> tog_q != $past(tog_q))
      else $error("toggle did not flip");
   toggle_first_a: assert property ($rose(gact_q) |-> !tog_q)
      else $error("first reply toggle not zero");
   state_code_a: assert property (st_q inside {7'h00, 7'h04, 7'h05, 7'h7F})
      else $error("illegal state code");
   boot_msg_a: assert property (boot_leave |=> st_q == cnmt_pkg::CNMT_PREOP
      && txv_q && txid_q == cnmt_pkg::ID_GUARD + 11'(node_q) && txdat_q[7:0] == 8'h00)
      else $error("boot-up not sent");
   nmt_start_a: assert property (nmt_hit && cs == cnmt_pkg::CS_START && !tmo_evt
      |=> st_q == cnmt_pkg::CNMT_OPER) else $error("start ignored");
   nmt_reset_a: assert property (rst_cmd |=> !run && !tog_q ##1 !gact_q)
      else $error("reset comms incomplete");
   tmo_stop_a: assert property (tmo_evt && cmode_q |=> alarm_q
      && st_q == cnmt_pkg::CNMT_STOPPED && epend_q[cnmt_pkg::FS_TMO])
      else $error("timeout not acted on");
   foreign_guard_a: assert property (!grd_hit && !ld_guard && !nmt_hit
      |=> $stable(tog_q)) else $error("toggle moved without reply");
   emcy_fmt_a: assert property (ld_emcy |=> txv_q && txdlc_q == cnmt_pkg::DLC_EMCY
      && txid_q == cnmt_pkg::ID_EMCY + 11'(node_q) && txdat_q[23:16] == $past(fcls_q))
      else $error("emergency malformed");
   hb_excl_a: assert property (hb_q != 16'h0000 |=> !gact_q)
      else $error("guarding during heartbeat");
endmodule

// ### rtl/cnmt_pkg.sv
// Constants for the CANopen slave network-management block.
// Assumes a 10 MHz clock and an 11-bit identifier frame interface.
package cnmt_pkg;
   localparam logic [10:0] ID_NMT     = 11'h000;
   localparam logic [10:0] ID_GUARD   = 11'h700;
   localparam logic [10:0] ID_EMCY    = 11'h080;
   localparam logic [7:0]  CS_START   = 8'h01;
   localparam logic [7:0]  CS_STOP    = 8'h02;
   localparam logic [7:0]  CS_PREOP   = 8'h80;
   localparam logic [7:0]  CS_PREOP2  = 8'h81;
   localparam logic [7:0]  CS_RSTCOM  = 8'h82;
   localparam logic [3:0]  DLC_GUARD  = 4'h1;
   localparam logic [3:0]  DLC_NMT    = 4'h2;
   localparam logic [3:0]  DLC_EMCY   = 4'h8;
   localparam int          TOG_BIT    = 7;
   // Node state codes; a guard reply never carries CNMT_INIT
   typedef enum logic [6:0] {
      CNMT_INIT    = 7'h00,
      CNMT_STOPPED = 7'h04,
      CNMT_OPER    = 7'h05,
      CNMT_PREOP   = 7'h7F
   } cnmt_state_t;
   localparam logic [6:0]  ST_DISC    = 7'h01;
   localparam logic [6:0]  ST_CONN    = 7'h02;
   localparam logic [6:0]  ST_PREP    = 7'h03;
   // Emergency codes
   localparam logic [15:0] EC_OVV     = 16'h3210;
   localparam logic [15:0] EC_UV      = 16'h3220;
   localparam logic [15:0] EC_OT      = 16'h4210;
   localparam logic [15:0] EC_ENC     = 16'h7331;
   localparam logic [15:0] EC_BUS     = 16'h8100;
   localparam logic [15:0] EC_TMO     = 16'h81FF;
   // Fault source index, lowest index is sent first
   localparam int          FS_OVV = 0, FS_UV = 1, FS_OT = 2;
   localparam int          FS_ENC = 3, FS_BUS = 4, FS_TMO = 5, FS_N = 6;
   // Fault class bits
   localparam int          FC_GEN = 0, FC_CUR = 1, FC_VOLT = 2, FC_TEMP = 3;
   localparam int          FC_COMM = 4, FC_PROF = 5, FC_ENC = 6;
   // Configuration port selects and defaults
   localparam logic [1:0]  CFG_GTIME  = 2'h0;
   localparam logic [1:0]  CFG_GFACT  = 2'h1;
   localparam logic [1:0]  CFG_HBTIME = 2'h2;
   localparam logic [1:0]  CFG_CMODE  = 2'h3;
   localparam logic [15:0] GTIME_DEF  = 16'h03E8;
   localparam logic [7:0]  GFACT_DEF  = 8'h03;
   localparam logic [15:0] HBTIME_DEF = 16'h0000;
   localparam logic        CMODE_DEF  = 1'b0;
   localparam logic        CMODE_STOP = 1'b1;
   // Timing
   localparam int          CLK_NS     = 32'h0000_0064;
   localparam int          MS_NS      = 32'h000F_4240;
   localparam int          MS_CYC     = MS_NS / CLK_NS;
   localparam logic [1:0]  INIT_WAIT  = 2'h3;
endpackage

// ### rtl/cnmt_tmr_if.sv
// Link between the slave core and its guard supervision timer.
// Assumes both ends share one clock.
interface cnmt_tmr_if;
   logic        restart;
   logic        halt;
   logic [15:0] time_ms;
   logic [7:0]  factor;
   logic        expire;
   modport ctl (output restart, halt, time_ms, factor, input expire);
   modport tmr (input restart, halt, time_ms, factor, output expire);
endinterface

// ### rtl/cnmt_guard_tmr.sv
// Guard supervision window: guard time times guard factor, in ms.
// Assumes restart is a one-cycle pulse from the core; halt is held high while a heartbeat time is set.
module cnmt_guard_tmr #(
   parameter int unsigned MS_CYCLES = cnmt_pkg::MS_CYC
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Core side
   cnmt_tmr_if.tmr   tif
);
   logic [31:0] pre_q, pre_d;
   logic [23:0] rem_q, rem_d;
   logic        run_q, run_d;
   logic        exp_q, exp_d;

   always_comb begin
      pre_d = pre_q;
      rem_d = rem_q;
      run_d = run_q;
      exp_d = 1'b0;
      if (tif.restart) begin
         rem_d = tif.time_ms * tif.factor;
         pre_d = '0;
         // Zero time or factor leaves supervision off
         run_d = (rem_d != '0);
      end else if (tif.halt) begin
         run_d = 1'b0;
      end else if (run_q) begin
         if (pre_q == 32'(MS_CYCLES - 1)) begin
            pre_d = '0;
            if (rem_q == 24'h000001) begin
               run_d = 1'b0;
               exp_d = 1'b1;
            end else begin
               rem_d = rem_q - 24'h000001;
            end
         end else begin
            pre_d = pre_q + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pre_q <= '0;
         rem_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         rem_q <= rem_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign tif.expire = exp_q;

   expire_run_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      exp_q |-> $past(run_q) && !run_q && $past(rem_q) == 24'h000001)
      else $error("expire without a running window");
endmodule

// ### sim/cnmt_master_model.sv
// Network master model: issues frames to the slave and accepts its frames.
// Assumes the slave's frame ports share clk_in; slow_in throttles acceptance.
module cnmt_master_model (
   // Clock and pacing
   input  wire logic        clk_in,
   input  wire logic        slow_in,
   // Frames towards the slave
   output logic             rx_valid_out,
   output logic [10:0]      rx_id_out,
   output logic             rx_rtr_out,
   output logic [3:0]       rx_dlc_out,
   output logic [63:0]      rx_data_out,
   // Acceptance of slave frames
   output logic             tx_ready_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        pend;
   logic [10:0] r_id;
   logic        r_rtr;
   logic [3:0]  r_dlc;
   logic [63:0] r_data;
   logic [1:0]  cnt;
   initial begin
      {pend, rx_valid_out, rx_id_out, rx_rtr_out, rx_dlc_out, rx_data_out} = '0;
      {tx_ready_out, cnt} = '0;
   end
   always @(posedge clk_in) begin
      cnt          <= cnt + 2'h1;
      tx_ready_out <= !slow_in || (cnt == 2'h3);
      if (pend) begin
         rx_valid_out <= 1'b1;
         rx_id_out    <= r_id;
         rx_rtr_out   <= r_rtr;
         rx_dlc_out   <= r_dlc;
         rx_data_out  <= r_data;
         pend         <= 1'b0;
      end else begin
         // Idle lines keep moving so a stale field can never look valid
         rx_valid_out <= 1'b0;
         rx_id_out    <= ~rx_id_out;
         rx_rtr_out   <= ~rx_rtr_out;
         rx_dlc_out   <= ~rx_dlc_out;
         rx_data_out  <= ~rx_data_out;
      end
   end
   // Only this model issues guard requests and module commands
   task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
                       input logic [63:0] data);
      @(negedge clk_in);
      r_id   = id;
      r_rtr  = rtr;
      r_dlc  = dlc;
      r_data = data;
      pend   = 1'b1;
      @(posedge clk_in);
      #1;
   endtask
endmodule

// ### sim/cnmt_slave_test.sv
// Self-checking bench for the slave network-management block.
// Assumes the master model in cnmt_master_model.sv and a shortened millisecond.
module cnmt_slave_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned MSC  = 10;
   localparam logic [6:0]  NODE = 7'h05;
   typedef struct {
      logic [10:0] id;
      logic [3:0]  dlc;
      logic [63:0] data;
      logic [63:0] mask;
   } cnmt_exp_t;
   logic        clk_in, resetn_in, slow, cfg_wr_in, rx_valid_in, rx_rtr_in, tx_valid_out;
   logic [1:0]  cfg_sel_in;
   logic [15:0] cfg_data_in, es1, es2, codes [5];
   logic [10:0] rx_id_in, tx_id_out;
   logic [3:0]  rx_dlc_in, tx_dlc_out;
   logic [63:0] rx_data_in, tx_data_out;
   logic        tx_ready_in, guard_active_out, comm_err_out, alarm_out, tog;
   logic [4:0]  flt;
   logic [6:0]  node_state_out, st;
   logic [7:0]  fault_class_out;
   logic [7:0]  cs_tab [6], nd_tab [6];
   logic [6:0]  st_tab [6];
   int          mismatches, n_checks, k;
   integer      seed;
   cnmt_exp_t   q [$];
   cnmt_exp_t   got;
   cnmt_slave #(.MS_CYCLES(MSC)) DUT (
      .clk_in(clk_in), .resetn_in(resetn_in), .station_in(NODE),
      .cfg_wr_in(cfg_wr_in), .cfg_sel_in(cfg_sel_in), .cfg_data_in(cfg_data_in),
      .rx_valid_in(rx_valid_in), .rx_id_in(rx_id_in), .rx_rtr_in(rx_rtr_in),
      .rx_dlc_in(rx_dlc_in), .rx_data_in(rx_data_in),
      .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .tx_id_out(tx_id_out),
      .tx_dlc_out(tx_dlc_out), .tx_data_out(tx_data_out),
      .flt_ovv_in(flt[0]), .flt_uv_in(flt[1]), .flt_ot_in(flt[2]), .flt_enc_in(flt[3]),
      .flt_bus_in(flt[4]), .err_state1_in(es1), .err_state2_in(es2),
      .node_state_out(node_state_out), .guard_active_out(guard_active_out),
      .comm_err_out(comm_err_out), .alarm_out(alarm_out), .fault_class_out(fault_class_out));
   cnmt_master_model M (
      .clk_in(clk_in), .slow_in(slow), .rx_valid_out(rx_valid_in), .rx_id_out(rx_id_in),
      .rx_rtr_out(rx_rtr_in), .rx_dlc_out(rx_dlc_in), .rx_data_out(rx_data_in),
      .tx_ready_out(tx_ready_in));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic expect_frame(input logic [10:0] id, input logic [3:0] dlc,
                               input logic [63:0] data, input logic [63:0] mask);
      cnmt_exp_t e;
      e.id   = id;
      e.dlc  = dlc;
      e.data = data;
      e.mask = mask;
      q.push_back(e);
   endtask
   task automatic wait_q(input string name);
      int i;
      for (i = 0; i < 3000 && q.size() != 0; i++) @(posedge clk_in);
      if (q.size() != 0) begin
         mismatches++;
         $display("unexpected at %0t: frame missing in %s", $time, name);
         q.delete();
      end
      repeat (4) @(posedge clk_in);
      $display("test %s done", name);
   endtask
   // A wanted reply carries the tracked toggle and state
   task automatic guard(input logic [10:0] id, input logic reply);
      if (reply) begin
         expect_frame(cnmt_pkg::ID_GUARD + 11'(NODE), cnmt_pkg::DLC_GUARD,
                      {56'h0, tog, st}, 64'hFF);
         tog = ~tog;
      end
      M.send(id, 1'b1, 4'h0, 64'h0);
   endtask
   task automatic nmt(input logic [7:0] cs, input logic [7:0] node);
      M.send(cnmt_pkg::ID_NMT, 1'b0, cnmt_pkg::DLC_NMT, {48'h0, node, cs});
   endtask
   task automatic cfg(input logic [1:0] sel, input logic [15:0] data);
      @(posedge clk_in);
      cfg_wr_in   <= 1'b1;
      cfg_sel_in  <= sel;
      cfg_data_in <= data;
      @(posedge clk_in);
      cfg_wr_in   <= 1'b0;
   endtask
   // Restart after init or reset comms: boot-up first, toggle back to zero
   task automatic boot(input string name);
      st  = cnmt_pkg::CNMT_PREOP;
      tog = 1'b0;
      expect_frame(cnmt_pkg::ID_GUARD + 11'(NODE), cnmt_pkg::DLC_GUARD, 64'h0, 64'hFF);
      wait_q(name);
      check(64'(node_state_out), 64'(st), "boot state");
   endtask
   always @(posedge clk_in) begin
      if (resetn_in === 1'b1 && tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
         if (q.size() == 0) begin
            mismatches++;
            $display("unexpected at %0t: frame id %h not wanted", $time, tx_id_out);
         end else begin
            got = q.pop_front();
            check(64'(tx_id_out), 64'(got.id), "frame id");
            check(64'(tx_dlc_out), 64'(got.dlc), "frame length");
            check(tx_data_out & got.mask, got.data & got.mask, "frame data");
         end
      end
   end
   initial begin
      #(100 * 45000);
      mismatches++;
      $display("unexpected at %0t: run did not complete", $time);
      report_and_stop();
   end
   initial begin
      {resetn_in, slow, cfg_wr_in, cfg_sel_in, cfg_data_in, flt, es1, es2} = '0;
      {mismatches, n_checks} = '0;
      seed  = 32'h1185;
      codes = '{cnmt_pkg::EC_OVV, cnmt_pkg::EC_UV, cnmt_pkg::EC_OT, cnmt_pkg::EC_ENC,
                cnmt_pkg::EC_BUS};
      cs_tab = '{8'h01, 8'h02, 8'h80, 8'h01, 8'h01, 8'h81};
      nd_tab = '{8'h05, 8'h00, 8'h05, 8'h06, 8'h00, 8'h05};
      st_tab = '{7'h05, 7'h04, 7'h7F, 7'h7F, 7'h05, 7'h7F};
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      boot("boot-up");
      guard(cnmt_pkg::ID_GUARD + 11'(NODE), 1'b1);
      wait_q("default window");
      check(64'(guard_active_out), 64'h1, "guarding on");
      repeat (29900) @(posedge clk_in);
      check(64'(comm_err_out), 64'h0, "error before window");
      repeat (300) @(posedge clk_in);
      check(64'(comm_err_out), 64'h1, "error after window");
      check(64'(alarm_out), 64'h0, "mode 0 no alarm");
      check(64'(node_state_out), 64'(st), "mode 0 state kept");
      nmt(cnmt_pkg::CS_RSTCOM, 8'(NODE));
      boot("reset comms");
      check(64'(comm_err_out), 64'h0, "error cleared");
      cfg(cnmt_pkg::CFG_GTIME, 16'h0002);
      cfg(cnmt_pkg::CFG_GFACT, 16'h0003);
      slow <= 1'b1;
      guard(cnmt_pkg::ID_GUARD + 11'(NODE), 1'b1);
      guard(cnmt_pkg::ID_GUARD + 11'h006, 1'b0);
      guard(cnmt_pkg::ID_GUARD + 11'(NODE), 1'b1);
      wait_q("toggle");
      slow <= 1'b0;
      for (k = 0; k < 6; k++) begin
         nmt(cs_tab[k], nd_tab[k]);
         repeat (3) @(posedge clk_in);
         st = st_tab[k];
         check(64'(node_state_out), 64'(st), "command state");
         guard(cnmt_pkg::ID_GUARD + 11'(NODE), 1'b1);
         wait_q("command");
      end
      cfg(cnmt_pkg::CFG_HBTIME, 16'h0064);
      repeat (2) @(posedge clk_in);
      check(64'(guard_active_out), 64'h0, "guarding dropped");
      guard(cnmt_pkg::ID_GUARD + 11'(NODE), 1'b0);
      repeat (20) @(posedge clk_in);
      cfg(cnmt_pkg::CFG_HBTIME, 16'h0000);
      wait_q("heartbeat exclusion");
      @(posedge clk_in);
      es1 <= 16'($random(seed));
      es2 <= 16'($random(seed));
      flt <= 5'h1F;
      #1;
      for (k = 0; k < 5; k++)
         expect_frame(cnmt_pkg::ID_EMCY + 11'(NODE), cnmt_pkg::DLC_EMCY,
                      {es2, es1, 8'h00, 8'h5D, codes[k]}, '1);
      wait_q("emergency");
      check(64'(fault_class_out), 64'h5D, "fault classes");
      flt <= 5'h00;
      repeat (3) @(posedge clk_in);
      check(64'(fault_class_out), 64'h00, "classes cleared");
      nmt(cnmt_pkg::CS_RSTCOM, 8'h00);
      boot("broadcast reset");
      cfg(cnmt_pkg::CFG_GTIME, 16'h0002);
      cfg(cnmt_pkg::CFG_GFACT, 16'h0003);
      cfg(cnmt_pkg::CFG_CMODE, 16'h0001);
      guard(cnmt_pkg::ID_GUARD + 11'(NODE), 1'b1);
      wait_q("guard before timeout");
      expect_frame(cnmt_pkg::ID_EMCY + 11'(NODE), cnmt_pkg::DLC_EMCY,
                   {es2, es1, 8'h00, 8'h00, cnmt_pkg::EC_TMO}, 64'hFFFF_FFFF_FF00_FFFF);
      repeat (80) @(posedge clk_in);
      wait_q("timeout alarm");
      check(64'(comm_err_out), 64'h1, "timeout flagged");
      check(64'(alarm_out), 64'h1, "alarm raised");
      check(64'(node_state_out), 64'(cnmt_pkg::CNMT_STOPPED), "stopped");
      report_and_stop();
   end
endmodule
